// file: verilog/pcg_top.sv
// lower-port crossbar, gpio registers, pin drivers and port-3 edge interrupts
`timescale 1ns/10ps
`default_nettype none
module pcg_top #(
  parameter int NPORT = pcg_pkg::NPORT,
  parameter int NPIN = pcg_pkg::NPIN,
  parameter int NFUNC = pcg_pkg::NFUNC
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire pcg_pkg::pcg_bus_req_t bus_in,
  output logic [7:0] rd_data_out,
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe_out,
  output logic [NPIN-1:0] pullup_en_out,
  input wire logic [NFUNC-1:0] periph_val_in,
  input wire logic [NFUNC-1:0] periph_drv_in,
  output logic [NFUNC-1:0] periph_level_out,
  input wire logic serial_a_mode0_in,
  input wire logic serial_b_mode0_in,
  input wire pcg_pkg::pcg_memif_t memif_in,
  output logic ext_irq_a_flag_out,
  output logic ext_irq_b_flag_out
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0] port_data [NPORT];
  logic [7:0] port_output_mode [NPORT];
  logic [7:0] port1_input_mode;
  logic [7:0] allocator_config_0;
  logic [7:0] allocator_config_1;
  logic [7:0] allocator_config_2;
  logic [7:0] port3_irq_reg;
  logic [NPIN-1:0] data_vec;
  logic [NPIN-1:0] mode_vec;
  logic [NPIN-1:0] rd_level;
  logic allocator_global_enable;
  logic pullup_global_disable;
  logic memif_low_port_enable;
  // port index for a data or mode address
  function automatic logic [1:0] port_idx(input logic [7:0] a);
    return a[1:0];
  endfunction : port_idx
  // address falls in a four-register bank
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + 8'h04);
  endfunction : in_bank
  assign allocator_global_enable = allocator_config_2[pcg_pkg::B_XBAR_EN];
  assign pullup_global_disable = allocator_config_2[pcg_pkg::B_PULLUP_DIS];
  assign memif_low_port_enable = allocator_config_2[pcg_pkg::B_MEMIF_LOW];
  // flatten per-port registers into pin vectors
  for (genvar g = 0; g < NPORT; g++) begin : g_flat
    assign data_vec[g*8 +: 8] = port_data[g];
    assign mode_vec[g*8 +: 8] = port_output_mode[g];
  end
  // pin level as read back; analog port-1 pins read 0
  always_comb begin
    rd_level = pin_in;
    rd_level[15:8] = pin_in[15:8] & port1_input_mode;
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // port data latches, byte and bit access
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < NPORT; i++) begin
        port_data[i] <= pcg_pkg::RST_DATA;
      end
    end else if (ce_in && in_bank(bus_in.addr, pcg_pkg::OFS_DATA0)) begin
      if (bus_in.wr) begin
        port_data[port_idx(bus_in.addr)] <= bus_in.wdata;
      end else if (bus_in.bit_wr) begin
        port_data[port_idx(bus_in.addr)][bus_in.bit_sel] <= bus_in.wdata[0];
      end
    end
  end

  // output-mode registers, reset open-drain
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < NPORT; i++) begin
        port_output_mode[i] <= pcg_pkg::RST_MODE;
      end
    end else if (ce_in && bus_in.wr && in_bank(bus_in.addr, pcg_pkg::OFS_MODE0)) begin
      port_output_mode[port_idx(bus_in.addr)] <= bus_in.wdata;
    end
  end

  // allocator and input-mode configuration
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      port1_input_mode <= pcg_pkg::RST_INMODE;
      allocator_config_0 <= pcg_pkg::RST_CFG;
      allocator_config_1 <= pcg_pkg::RST_CFG;
      allocator_config_2 <= pcg_pkg::RST_CFG;
    end else if (ce_in && bus_in.wr) begin
      if (bus_in.addr == pcg_pkg::OFS_P1_INMODE) begin
        port1_input_mode <= bus_in.wdata;
      end else if (bus_in.addr == pcg_pkg::OFS_CFG0) begin
        allocator_config_0 <= bus_in.wdata;
      end else if (bus_in.addr == pcg_pkg::OFS_CFG1) begin
        allocator_config_1 <= bus_in.wdata;
      end else if (bus_in.addr == pcg_pkg::OFS_CFG2) begin
        allocator_config_2 <= bus_in.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // external edge interrupts
  // ------------------------------------------------------------
  logic edge_a;
  logic edge_b;
  logic irq_wr;

  pcg_edge u_edge_a (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .pin_in(pin_in[pcg_pkg::PIN_IRQ_A]),
    .rising_in(port3_irq_reg[pcg_pkg::B_POL_A]),
    .edge_out(edge_a)
  );

  pcg_edge u_edge_b (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .pin_in(pin_in[pcg_pkg::PIN_IRQ_B]),
    .rising_in(port3_irq_reg[pcg_pkg::B_POL_B]),
    .edge_out(edge_b)
  );

  assign irq_wr = ce_in && bus_in.wr && bus_in.addr == pcg_pkg::OFS_P3_IRQ;

  // flags set on edges; a set beats a same-cycle clear
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      port3_irq_reg <= pcg_pkg::RST_IRQ;
    end else if (ce_in) begin
      if (irq_wr) begin
        port3_irq_reg <= bus_in.wdata;
      end
      if (edge_a) begin
        port3_irq_reg[pcg_pkg::B_FLAG_A] <= 1'b1;
      end
      if (edge_b) begin
        port3_irq_reg[pcg_pkg::B_FLAG_B] <= 1'b1;
      end
    end
  end

  assign ext_irq_a_flag_out = port3_irq_reg[pcg_pkg::B_FLAG_A];
  assign ext_irq_b_flag_out = port3_irq_reg[pcg_pkg::B_FLAG_B];

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  logic [7:0] next_rd;

  // latch on read-modify-write, pins otherwise
  always_comb begin
    next_rd = 8'h00;
    if (in_bank(bus_in.addr, pcg_pkg::OFS_DATA0)) begin
      if (bus_in.rmw) begin
        next_rd = port_data[port_idx(bus_in.addr)];
      end else begin
        next_rd = rd_level[port_idx(bus_in.addr)*8 +: 8];
      end
    end else if (in_bank(bus_in.addr, pcg_pkg::OFS_MODE0)) begin
      next_rd = port_output_mode[port_idx(bus_in.addr)];
    end else if (bus_in.addr == pcg_pkg::OFS_P1_INMODE) begin
      next_rd = port1_input_mode;
    end else if (bus_in.addr == pcg_pkg::OFS_CFG0) begin
      next_rd = allocator_config_0;
    end else if (bus_in.addr == pcg_pkg::OFS_CFG1) begin
      next_rd = allocator_config_1;
    end else if (bus_in.addr == pcg_pkg::OFS_CFG2) begin
      next_rd = allocator_config_2;
    end else if (bus_in.addr == pcg_pkg::OFS_P3_IRQ) begin
      next_rd = port3_irq_reg;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= 8'h00;
    end else if (ce_in) begin
      rd_data_out <= bus_in.rd ? next_rd : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // allocation
  // ------------------------------------------------------------
  logic [NFUNC-1:0] func_en;
  logic [NPIN-1:0] skip;
  logic [NPIN-1:0] assigned;
  logic [NPIN-1:0][3:0] func;
  logic [2:0] cntr_cnt;

  assign cntr_cnt = allocator_config_0[pcg_pkg::B_CNTR_LSB +: 3];

  // whole groups enabled by one bit each; counter outputs enabled by a 3-bit count
  always_comb begin
    func_en = '0;
    func_en[pcg_pkg::F_TXA +: 2] = {2{allocator_config_0[pcg_pkg::B_SERIAL_A_EN]}};
    func_en[pcg_pkg::F_SCK +: 4] = {4{allocator_config_0[pcg_pkg::B_SPI_EN]}};
    func_en[pcg_pkg::F_SDA +: 2] = {2{allocator_config_0[pcg_pkg::B_SMBUS_EN]}};
    func_en[pcg_pkg::F_TXB +: 2] = {2{allocator_config_2[pcg_pkg::B_SERIAL_B_EN]}};
    for (int k = 0; k < 5; k++) begin
      func_en[pcg_pkg::F_CEX0 + k] = (cntr_cnt > 3'(k));
    end
    func_en[pcg_pkg::F_CNV] = allocator_config_2[pcg_pkg::B_CNVST_EN];
  end

  // analog pins and reserved memory strobes are skipped
  always_comb begin
    skip = '0;
    skip[15:8] = ~port1_input_mode;
    if (memif_low_port_enable) begin
      skip[pcg_pkg::PIN_WRS] = 1'b1;
      skip[pcg_pkg::PIN_RDS] = 1'b1;
      skip[pcg_pkg::PIN_ALE] = memif_in.muxed;
    end
  end

  pcg_alloc #(
    .NPIN(NPIN),
    .NFUNC(NFUNC)
  ) u_alloc (
    .func_en_in(func_en),
    .skip_in(skip),
    .assigned_out(assigned),
    .func_out(func)
  );

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  logic [NPIN-1:0] next_out;
  logic [NPIN-1:0] next_oe;
  logic [NPIN-1:0] next_pu;
  logic [NPIN-1:0] in_func_pin;
  logic [NPIN-1:0] od_pin;
  logic [NFUNC-1:0] next_level;

  always_comb begin
    logic val;
    logic drv;
    logic [3:0] f;
    val = 1'b0;
    drv = 1'b0;
    f = 4'h0;
    next_level = '1;
    for (int p = 0; p < NPIN; p++) begin
      f = func[p];
      val = data_vec[p];
      drv = 1'b1;
      in_func_pin[p] = 1'b0;
      od_pin[p] = !mode_vec[p];
      if (assigned[p]) begin
        // peripheral owns the output, data latch ignored
        val = periph_val_in[f];
        drv = periph_drv_in[f] && !pcg_pkg::FUNC_INPUT_MASK[f];
        in_func_pin[p] = pcg_pkg::FUNC_INPUT_MASK[f];
        next_level[f] = rd_level[p];
        // smbus and mode-0 receive pins forced open-drain
        if (f == 4'(pcg_pkg::F_SDA) || f == 4'(pcg_pkg::F_SCL) ||
            (f == 4'(pcg_pkg::F_RXA) && serial_a_mode0_in) ||
            (f == 4'(pcg_pkg::F_RXB) && serial_b_mode0_in)) begin
          od_pin[p] = 1'b1;
          drv = periph_drv_in[f];
          in_func_pin[p] = 1'b0; // bidirectional here, not a pure input
        end
      end
      if (memif_low_port_enable && memif_in.active && memif_in.pin_mask[p]) begin
        // memory interface overrides during external moves
        val = memif_in.pin_val[p];
        drv = !(memif_in.read && memif_in.dbus_mask[p]);
        in_func_pin[p] = 1'b0;
      end
      // with global enable and drive, low in either mode, high only in push-pull
      next_out[p] = val;
      next_oe[p] = allocator_global_enable && drv && (!val || !od_pin[p]);
      // pull-up off when driving low, globally, or analog
      next_pu[p] = !pullup_global_disable && !(next_oe[p] && !val) && !(skip[p] && p / 8 == 1);
    end
  end

  // registered pin and peripheral outputs
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_out <= '1;
      pin_oe_out <= '0;
      pullup_en_out <= '1;
      periph_level_out <= '1;
    end else if (ce_in) begin
      pin_out <= next_out;
      pin_oe_out <= next_oe;
      pullup_en_out <= next_pu;
      periph_level_out <= next_level;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  xbar_off_a: assert property ((ce_in && !allocator_global_enable) |=> pin_oe_out == '0)
    else $error("driver enabled before global enable");
  input_drv_a: assert property (ce_in |=> (pin_oe_out & $past(in_func_pin)) == '0)
    else $error("driver on peripheral input pin");
  od_high_a: assert property (ce_in |=> (pin_oe_out & pin_out & $past(od_pin)) == '0)
    else $error("open-drain pin driven high");
  pullup_low_a: assert property ((pullup_en_out & pin_oe_out & ~pin_out) == '0)
    else $error("pull-up on while driving low");
  pullup_dis_a: assert property ((ce_in && pullup_global_disable) |=> pullup_en_out == '0)
    else $error("pull-up on while globally disabled");
  analog_read_a: assert property ((ce_in && bus_in.rd && !bus_in.rmw &&
      bus_in.addr == pcg_pkg::OFS_DATA0 + 8'h01) |=>
      (rd_data_out & ~$past(port1_input_mode)) == 8'h00)
    else $error("analog pin read nonzero");
  rmw_read_a: assert property ((ce_in && bus_in.rd && bus_in.rmw &&
      bus_in.addr == pcg_pkg::OFS_DATA0) |=> rd_data_out == $past(port_data[0]))
    else $error("rmw read not from latch");
  irq_set_a: assert property (edge_a |=> ext_irq_a_flag_out)
    else $error("edge did not set flag");
  skip_pin_a: assert property ((assigned & skip) == '0)
    else $error("skipped pin assigned");
  memif_rsv_a: assert property (memif_low_port_enable |-> assigned[7:6] == 2'b00)
    else $error("memory strobe pin assigned");
endmodule : pcg_top
`default_nettype wire

// file: verilog/pcg_pkg.sv
// shared constants and carrier types for the port crossbar and gpio block
package pcg_pkg;
  localparam int NPORT = 4;
  localparam int NPIN = 32;
  localparam int NFUNC = 16;
  // register offsets
  localparam logic [7:0] OFS_DATA0 = 8'h00; // port data 0..3
  localparam logic [7:0] OFS_MODE0 = 8'h04; // port_output_mode 0..3
  localparam logic [7:0] OFS_P1_INMODE = 8'h08;
  localparam logic [7:0] OFS_CFG0 = 8'h09;
  localparam logic [7:0] OFS_CFG1 = 8'h0a;
  localparam logic [7:0] OFS_CFG2 = 8'h0b;
  localparam logic [7:0] OFS_P3_IRQ = 8'h0c;
  // allocator_config_0 fields
  localparam int B_SMBUS_EN = 0;
  localparam int B_SPI_EN = 1;
  localparam int B_SERIAL_A_EN = 2;
  localparam int B_CNTR_LSB = 3; // 3-bit field at [5:3]
  // allocator_config_2 fields
  localparam int B_CNVST_EN = 0;
  localparam int B_MEMIF_LOW = 1;
  localparam int B_SERIAL_B_EN = 2;
  localparam int B_XBAR_EN = 6;
  localparam int B_PULLUP_DIS = 7;
  // port3_irq_reg fields
  localparam int B_POL_A = 2;
  localparam int B_POL_B = 3;
  localparam int B_FLAG_A = 6;
  localparam int B_FLAG_B = 7;
  // reset values
  localparam logic [7:0] RST_DATA = 8'hff;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_INMODE = 8'hff;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_IRQ = 8'h00;
  // peripheral function slots in priority order
  localparam int F_TXA = 0;
  localparam int F_RXA = 1;
  localparam int F_SCK = 2;
  localparam int F_SDA = 6;
  localparam int F_SCL = 7;
  localparam int F_TXB = 8;
  localparam int F_RXB = 9;
  localparam int F_CEX0 = 10;
  localparam int F_CNV = 15;
  localparam logic [15:0] FUNC_INPUT_MASK = 16'h8202;
  // fixed pin numbers
  localparam int PIN_ALE = 5;
  localparam int PIN_RDS = 6;
  localparam int PIN_WRS = 7;
  localparam int PIN_IRQ_A = 30;
  localparam int PIN_IRQ_B = 31;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic rmw;
  } pcg_bus_req_t;

  typedef struct packed {
    logic active;
    logic read;
    logic muxed;
    logic [31:0] pin_mask;
    logic [31:0] pin_val;
    logic [31:0] dbus_mask;
  } pcg_memif_t;
endpackage : pcg_pkg

// file: verilog/pcg_edge.sv
// synchronised edge detector for one external interrupt pin
`timescale 1ns/10ps
`default_nettype none
module pcg_edge (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic pin_in,
  input wire logic rising_in,
  output logic edge_out
);
  logic sync1;
  logic sync2;
  logic prev;

  // two-flop synchroniser plus previous sample
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1 <= 1'b1; // pulled-up idle level, no false edge after reset
      sync2 <= 1'b1;
      prev <= 1'b1;
    end else if (ce_in) begin
      sync1 <= pin_in;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // one pulse per qualifying edge
  assign edge_out = ce_in && (rising_in ? (sync2 && !prev) : (!sync2 && prev));
endmodule : pcg_edge
`default_nettype wire

// file: verilog/pcg_alloc.sv
// priority pin allocator: maps enabled functions onto free pins
`timescale 1ns/10ps
`default_nettype none
module pcg_alloc #(
  parameter int NPIN = 32,
  parameter int NFUNC = 16
) (
  input wire logic [NFUNC-1:0] func_en_in,
  input wire logic [NPIN-1:0] skip_in,
  output logic [NPIN-1:0] assigned_out,
  output logic [NPIN-1:0][3:0] func_out
);
  logic [5:0] rank [NFUNC];

  // rank of each enabled function among the enabled ones
  always_comb begin
    logic [5:0] cnt;
    cnt = '0;
    for (int f = 0; f < NFUNC; f++) begin
      rank[f] = cnt;
      cnt = cnt + {5'h00, func_en_in[f]};
    end
  end

  // walk pins upward, skipping reserved ones
  always_comb begin
    logic [5:0] ord;
    ord = '0;
    for (int p = 0; p < NPIN; p++) begin
      assigned_out[p] = 1'b0;
      func_out[p] = 4'h0;
      if (!skip_in[p]) begin
        for (int f = 0; f < NFUNC; f++) begin
          if (func_en_in[f] && rank[f] == ord) begin
            assigned_out[p] = 1'b1;
            func_out[p] = 4'(f);
          end
        end
        ord = ord + 6'h01;
      end
    end
  end
endmodule : pcg_alloc
`default_nettype wire

// file: tb/pcg_pin_model.sv
// model of the package pins and the circuits hung on them
`timescale 1ns/10ps
`default_nettype none
module pcg_pin_model (
  input wire logic core_clk_in,
  input wire logic [31:0] pin_out_in,
  input wire logic [31:0] pin_oe_in,
  input wire logic [31:0] pullup_en_in,
  input wire logic [31:0] ext_drv_in,
  input wire logic [31:0] ext_val_in,
  output logic [31:0] level_out
);
  // ----------------------------------------
  // wire resolution
  // ----------------------------------------
  logic [31:0] last;

  // device driver wins, then outside driver, then pull-up, else a floating wire
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pin_oe_in[i]) begin
        level_out[i] = pin_out_in[i];
      end else if (ext_drv_in[i]) begin
        level_out[i] = ext_val_in[i];
      end else if (pullup_en_in[i]) begin
        level_out[i] = 1'b1;
      end else begin
        level_out[i] = ~last[i]; // floating: never shows a stable value
      end
    end
  end

  // remembers the previous level for the floating case
  always_ff @(posedge core_clk_in) begin
    last <= level_out;
  end
endmodule : pcg_pin_model
`default_nettype wire

// file: tb/port_crossbar_gpio_bench.sv
// self-checking bench for the port crossbar and gpio block
`timescale 1ns/10ps
`default_nettype none
module port_crossbar_gpio_bench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  pcg_pkg::pcg_bus_req_t bus = '0;
  pcg_pkg::pcg_memif_t memif = '0;
  logic [15:0] pval = '0;
  logic [15:0] pdrv = 16'hffff;
  logic [31:0] edrv = '0;
  logic [31:0] eval = '0;
  logic ce = 1'b1;
  logic m0 = 1'b0;
  logic [7:0] rd_data;
  logic [31:0] lvl, pout, poe, pup;
  logic [15:0] plev;
  logic fa, fb;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;

  always #5 core_clk_in = ~core_clk_in;

  pcg_top u_pcg_top (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .ce_in(ce), .bus_in(bus),
    .rd_data_out(rd_data), .pin_in(lvl), .pin_out(pout), .pin_oe_out(poe),
    .pullup_en_out(pup), .periph_val_in(pval), .periph_drv_in(pdrv),
    .periph_level_out(plev), .serial_a_mode0_in(m0), .serial_b_mode0_in(m0),
    .memif_in(memif), .ext_irq_a_flag_out(fa), .ext_irq_b_flag_out(fb)
  );

  pcg_pin_model u_pcg_pin_model (
    .core_clk_in(core_clk_in), .pin_out_in(pout), .pin_oe_in(poe),
    .pullup_en_in(pup), .ext_drv_in(edrv), .ext_val_in(eval), .level_out(lvl)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : step

  // k: 0 write, 1 read, 2 latch read, 3 bit write (bit in d[6:4], value d[0])
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input int k);
    pcg_pkg::pcg_bus_req_t r;
    r = '0;
    r.addr = a;
    r.wdata = d;
    r.wr = (k == 0);
    r.rd = (k == 1 || k == 2);
    r.rmw = (k == 2);
    r.bit_wr = (k == 3);
    r.bit_sel = d[6:4];
    @(posedge core_clk_in);
    bus <= r;
    @(posedge core_clk_in);
    bus <= '0;
    #1;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, d, 0);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, input bit m, input logic [7:0] e);
    xfer(a, 8'h00, m ? 2 : 1);
    chk(n, {24'h0, e}, {24'h0, rd_data});
  endtask : rd

  task automatic ext(input logic [31:0] d, input logic [31:0] v);
    @(posedge core_clk_in);
    edrv <= d;
    eval <= v;
  endtask : ext

  task automatic mem(input logic a, input logic r);
    @(posedge core_clk_in);
    memif <= '{active: a, read: r, muxed: 1'b1, pin_mask: 32'h84, pin_val: 32'h0,
               dbus_mask: 32'h4};
  endtask : mem

  // cycle ceiling against hangs
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    step(2);
    chk("oe", 32'h0, poe);
    chk("pullup", 32'hffffffff, pup);
    rd("latch0", pcg_pkg::OFS_DATA0, 1, 8'hff);
    rd("mode0", pcg_pkg::OFS_MODE0, 0, 8'h00);
    rd("inmode", pcg_pkg::OFS_P1_INMODE, 0, 8'hff);
    rd("unmapped", 8'h3f, 0, 8'h00);
    rd("pins0", pcg_pkg::OFS_DATA0, 0, 8'hff);
    $display("test reset done");
    wr(pcg_pkg::OFS_MODE0, 8'hff);
    wr(pcg_pkg::OFS_DATA0, 8'h00);
    step(3);
    chk("oe gated", 32'h0, poe);
    wr(pcg_pkg::OFS_CFG2, 8'h40);
    step(3);
    chk("oe p0", 8'hff, poe[7:0]);
    chk("out p0", 8'h00, pout[7:0]);
    chk("pullup p0", 8'h00, pup[7:0]);
    rd("pins0", pcg_pkg::OFS_DATA0, 0, 8'h00);
    wr(pcg_pkg::OFS_DATA0, 8'h0f);
    step(3);
    chk("out pp", 8'h0f, pout[7:0]);
    chk("oe pp", 8'hff, poe[7:0]);
    wr(pcg_pkg::OFS_MODE0, 8'h00);
    step(3);
    chk("oe od", 8'hf0, poe[7:0]);
    chk("pullup od", 8'h0f, pup[7:0]);
    xfer(pcg_pkg::OFS_DATA0, 8'h71, 3);
    rd("latch0", pcg_pkg::OFS_DATA0, 1, 8'h8f);
    ext(32'h1, 32'h0);
    step(2);
    rd("pins0", pcg_pkg::OFS_DATA0, 0, 8'h8e);
    ext(32'h0, 32'h0);
    $display("test gpio done");
    @(posedge core_clk_in);
    pval <= 16'hffff;
    wr(pcg_pkg::OFS_MODE0, 8'hff);
    wr(pcg_pkg::OFS_DATA0, 8'h00);
    wr(pcg_pkg::OFS_CFG0, 8'h04);
    step(3);
    chk("oe serial a", 8'hfd, poe[7:0]);
    chk("out serial a", 8'h01, pout[7:0] & 8'hfd);
    ext(32'h2, 32'h0);
    step(3);
    chk("rx level", 1'b0, plev[1]);
    ext(32'h0, 32'h0);
    @(posedge core_clk_in);
    pval <= 16'h0000;
    wr(pcg_pkg::OFS_CFG0, 8'h07);
    step(3);
    chk("oe p0 full", 8'hfd, poe[7:0]);
    chk("out p0 full", 8'h00, pout[7:0] & 8'hfd);
    wr(pcg_pkg::OFS_CFG2, 8'h44);
    step(3);
    chk("oe serial b", 3'b001, poe[10:8]);
    wr(pcg_pkg::OFS_P1_INMODE, 8'hfe);
    ext(32'h100, 32'h100);
    step(3);
    chk("oe skip", 3'b010, poe[10:8]);
    chk("analog hiz", 1'b1, pout[8]);
    chk("pullup analog", 1'b0, pup[8]);
    rd("pins1", pcg_pkg::OFS_DATA0 + 8'h01, 0, 8'hfc);
    ext(32'h0, 32'h0);
    @(posedge core_clk_in);
    pval <= 16'hffff;
    step(3);
    chk("oe smbus", 2'b00, poe[7:6]);
    chk("oe tx pp", 1'b1, poe[0]);
    @(posedge core_clk_in);
    m0 <= 1'b1;
    pval <= 16'hfffd;
    step(3);
    chk("oe rx mode0", 1'b1, poe[1]);
    @(posedge core_clk_in);
    m0 <= 1'b0;
    $display("test allocator done");
    wr(pcg_pkg::OFS_P1_INMODE, 8'hff);
    wr(pcg_pkg::OFS_CFG0, 8'h06);
    wr(pcg_pkg::OFS_CFG2, 8'h42);
    wr(pcg_pkg::OFS_MODE0, 8'h00);
    wr(pcg_pkg::OFS_DATA0, 8'hff);
    @(posedge core_clk_in);
    pval <= 16'h0000;
    mem(1'b0, 1'b0);
    step(3);
    chk("oe reserved", 4'h8, poe[8:5]);
    mem(1'b1, 1'b0);
    step(3);
    chk("memif oe", 1'b1, poe[7]);
    chk("memif out", 1'b0, pout[7]);
    mem(1'b1, 1'b1);
    step(3);
    chk("dbus off", 1'b0, poe[2]);
    chk("ctl on", 1'b1, poe[7]);
    @(posedge core_clk_in);
    memif <= '0;
    $display("test memif done");
    wr(pcg_pkg::OFS_CFG0, 8'h00);
    wr(pcg_pkg::OFS_CFG2, 8'h40);
    ext(32'hc0000000, 32'h80000000);
    step(5);
    wr(pcg_pkg::OFS_P3_IRQ, 8'h04);
    step(2);
    chk("flags idle", 2'b00, {fa, fb});
    ext(32'hc0000000, 32'hc0000000);
    step(4);
    chk("flag a rise", 2'b10, {fa, fb});
    rd("irq reg", pcg_pkg::OFS_P3_IRQ, 0, 8'h44);
    ext(32'hc0000000, 32'h40000000);
    step(4);
    chk("flag b fall", 2'b11, {fa, fb});
    wr(pcg_pkg::OFS_P3_IRQ, 8'h04);
    step(2);
    chk("flags clear", 2'b00, {fa, fb});
    ext(32'hc0000000, 32'h80000000);
    step(4);
    chk("wrong edges", 2'b00, {fa, fb});
    $display("test edges done");
    @(posedge core_clk_in);
    ce <= 1'b0;
    wr(pcg_pkg::OFS_CFG2, 8'hc0);
    @(posedge core_clk_in);
    ce <= 1'b1;
    step(3);
    chk("ce freeze", 32'hffffffff, pup);
    wr(pcg_pkg::OFS_CFG2, 8'hc0);
    step(3);
    chk("pullup off", 32'h0, pup);
    $display("test pullup done");
    wrap_up();
  end
endmodule : port_crossbar_gpio_bench
`default_nettype wire
